// file: src/amc_regs.sv
// mode-control register bank of a four-channel converter
//
// What this block does
// - each low power bit naps its own channel, in any combination
// - top power bit puts device to sleep, all channels off
// - all power bits clear means every channel converts normally
// - termination bit enables termination and doubles driver current
// - test enable bit swaps conversion data for the test word
// - pattern high bits 5-0 give test word bits 13 to 8
// - pattern low bits 7-2 give test word bits 7 to 2
// - pattern low bits 1-0 give the two extra test word bits
// - pattern high bit 6 is stored but has no effect
// - access is 16-bit word: flag, seven address, eight data bits
// - software reset zeroes registers, sleeps briefly, then self-clears
`timescale 1ns/1ps
module amc_regs
  import amc_pkg::*;
#(
  parameter int DATA_W = 14
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // configuration pins
  input wire logic programming_mode_select_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // conversion data path
  input wire logic [DATA_W-1:0] conv_data_i,
  output logic [DATA_W-1:0] out_data_o,
  output logic out_drive_en_o,
  // power state
  output logic sleep_o,
  output logic [NUM_CHAN-1:0] chan_nap_o,
  output logic [NUM_CHAN-1:0] chan_run_o,
  // output driver settings
  output logic [2:0] driver_current_code_o,
  output logic internal_termination_enable_o,
  output logic [13:0] drive_current_ua_o,
  output logic output_disable_o,
  // serialization
  output logic [2:0] lane_serialization_mode_o,
  output logic two_lane_o,
  output logic [4:0] frame_bits_o,
  output logic lane_mode_valid_o,
  // test pattern
  output logic test_pattern_enable_o
);

  // ==========================================================
  // pin synchronisers
  logic [3:0] pins_s;
  amc_sync #(
    .WIDTH(4),
    .RST_VAL(4'h4)
  ) u_sync (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .async_i({programming_mode_select_i, cs_n_i, sck_i, sdi_i}),
    .sync_o(pins_s)
  );

  // the serial port is held idle while pin programming is selected
  wire port_cs_n = pins_s[2] | pins_s[3];

  // ==========================================================
  // serial port engine
  logic [6:0] acc_addr;
  logic [7:0] acc_wdata;
  logic acc_wr;
  logic [7:0] acc_rdata;
  logic sdo_oe;

  amc_spi_port u_port (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .cs_n_i(port_cs_n),
    .sck_i(pins_s[1]),
    .sdi_i(pins_s[0]),
    .rdata_i(acc_rdata),
    .addr_o(acc_addr),
    .wdata_o(acc_wdata),
    .wr_o(acc_wr),
    .sdo_oe_o(sdo_oe)
  );

  // ==========================================================
  // register storage
  logic [7:0] fmt_reg;
  logic [7:0] fmt_next;
  logic [7:0] omode_reg;
  logic [7:0] omode_next;
  logic [7:0] phi_reg;
  logic [7:0] phi_next;
  logic [7:0] plo_reg;
  logic [7:0] plo_next;
  logic [3:0] srst_cnt_reg;
  logic [3:0] srst_cnt_next;

  // ==========================================================
  // write decode
  wire hit_reset = acc_addr == ADDR_RESET;
  wire hit_fmt = acc_addr == ADDR_FMT_PWR;
  wire hit_omode = acc_addr == ADDR_OUT_MODE;
  wire hit_phi = acc_addr == ADDR_PAT_HI;
  wire hit_plo = acc_addr == ADDR_PAT_LO;
  wire srst_busy = srst_cnt_reg != 4'h0;
  wire srst_go = acc_wr & hit_reset & acc_wdata[SRST_BIT];
  // writes landing during the reset window are dropped
  wire wr_ok = acc_wr & ~srst_busy & ~srst_go;

  // reads never reach the update path
  assign fmt_next = srst_go ? REG_RESET_VAL :
    (wr_ok & hit_fmt) ? acc_wdata : fmt_reg;
  assign omode_next = srst_go ? REG_RESET_VAL :
    (wr_ok & hit_omode) ? acc_wdata : omode_reg;
  assign phi_next = srst_go ? REG_RESET_VAL :
    (wr_ok & hit_phi) ? acc_wdata : phi_reg;
  assign plo_next = srst_go ? REG_RESET_VAL :
    (wr_ok & hit_plo) ? acc_wdata : plo_reg;
  assign srst_cnt_next = srst_go ? SRST_CYCLES :
    srst_busy ? srst_cnt_reg - 4'h1 : 4'h0;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fmt_reg <= REG_RESET_VAL;
      omode_reg <= REG_RESET_VAL;
      phi_reg <= REG_RESET_VAL;
      plo_reg <= REG_RESET_VAL;
      srst_cnt_reg <= 4'h0;
    end else begin
      fmt_reg <= fmt_next;
      omode_reg <= omode_next;
      phi_reg <= phi_next;
      plo_reg <= plo_next;
      srst_cnt_reg <= srst_cnt_next;
    end
  end

  // ==========================================================
  // readback; unmapped addresses read as zero
  wire [7:0] reset_rd = {srst_busy, 7'h00};
  assign acc_rdata = hit_reset ? reset_rd :
    hit_fmt ? fmt_reg :
    hit_omode ? omode_reg :
    hit_phi ? phi_reg :
    hit_plo ? plo_reg : 8'h00;

  // ==========================================================
  // power state
  // the reset window reuses sleep so the converter pauses while fields clear
  // sleep overrides naps
  wire sleep_w = fmt_reg[SLEEP_BIT] | srst_busy;
  wire [NUM_CHAN-1:0] nap_w;
  wire [NUM_CHAN-1:0] run_w;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      assign nap_w[ch] = fmt_reg[ch] & ~sleep_w;
      assign run_w[ch] = ~fmt_reg[ch] & ~sleep_w;
    end
  endgenerate

  // ==========================================================
  // driver current
  amc_cur_t cur_code;
  logic [13:0] cur_base;
  assign cur_code = amc_cur_t'(omode_reg[CUR_MSB:CUR_LSB]);

  always_comb begin
    unique case (cur_code)
      CUR_3P5: cur_base = UA_3P5;
      CUR_4P0: cur_base = UA_4P0;
      CUR_4P5: cur_base = UA_4P5;
      CUR_NONE: cur_base = 14'h0000;
      CUR_3P0: cur_base = UA_3P0;
      CUR_2P5: cur_base = UA_2P5;
      CUR_2P1: cur_base = UA_2P1;
      CUR_1P75: cur_base = UA_1P75;
    endcase
  end

  // no overflow: the largest base current doubled still fits 14 bits
  wire term_w = omode_reg[TERM_BIT];
  wire [13:0] cur_ua = term_w ? {cur_base[12:0], 1'b0} : cur_base;

  // ==========================================================
  // serialization mode
  amc_lane_t lane;
  logic two_lane;
  logic [4:0] frame_bits;
  logic lane_ok;
  assign lane = amc_lane_t'(omode_reg[MODE_MSB:0]);

  // unused codes fall back to the widest framing and are flagged invalid
  always_comb begin
    unique case (lane)
      LM_2L16: {two_lane, frame_bits, lane_ok} = {1'b1, 5'h10, 1'b1};
      LM_2L14: {two_lane, frame_bits, lane_ok} = {1'b1, 5'h0e, 1'b1};
      LM_2L12: {two_lane, frame_bits, lane_ok} = {1'b1, 5'h0c, 1'b1};
      LM_NU3: {two_lane, frame_bits, lane_ok} = {1'b1, 5'h10, 1'b0};
      LM_NU4: {two_lane, frame_bits, lane_ok} = {1'b1, 5'h10, 1'b0};
      LM_1L14: {two_lane, frame_bits, lane_ok} = {1'b0, 5'h0e, 1'b1};
      LM_1L16A: {two_lane, frame_bits, lane_ok} = {1'b0, 5'h10, 1'b1};
      LM_1L16B: {two_lane, frame_bits, lane_ok} = {1'b0, 5'h10, 1'b1};
    endcase
  end

  // ==========================================================
  // test pattern
  // pattern high bit 6 is never used in the test word, only read back
  wire [5:0] pat_hi = phi_reg[PHI_MSB:0];
  wire [5:0] pat_lo = plo_reg[7:2];
  // extra bits below the twelve data bits
  wire [1:0] pat_x = plo_reg[1:0];
  wire [13:0] test_word = {pat_hi, pat_lo, pat_x};
  wire test_en = phi_reg[TEST_EN_BIT];
  wire [DATA_W-1:0] data_w =
    test_en ? DATA_W'(test_word) : conv_data_i;
  wire drive_en_w = ~omode_reg[OFF_BIT];

  // ==========================================================
  // registered outputs
  // data path and pin enables
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_data_o <= '0;
      out_drive_en_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else begin
      out_data_o <= data_w;
      out_drive_en_o <= drive_en_w;
      sdo_oe_o <= sdo_oe;
    end
  end

  // power state
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sleep_o <= 1'b0;
      chan_nap_o <= '0;
      chan_run_o <= '0;
    end else begin
      sleep_o <= sleep_w;
      chan_nap_o <= nap_w;
      chan_run_o <= run_w;
    end
  end

  // driver current
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drive_current_ua_o <= 14'h0000;
    end else begin
      drive_current_ua_o <= cur_ua;
    end
  end

  // serialization
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      two_lane_o <= 1'b0;
      frame_bits_o <= 5'h00;
      lane_mode_valid_o <= 1'b0;
    end else begin
      two_lane_o <= two_lane;
      frame_bits_o <= frame_bits;
      lane_mode_valid_o <= lane_ok;
    end
  end

  // raw fields come straight from the register flops
  assign driver_current_code_o = omode_reg[CUR_MSB:CUR_LSB];
  assign internal_termination_enable_o = omode_reg[TERM_BIT];
  assign output_disable_o = omode_reg[OFF_BIT];
  assign lane_serialization_mode_o = omode_reg[MODE_MSB:0];
  assign test_pattern_enable_o = phi_reg[TEST_EN_BIT];
  // open drain only ever pulls low
  assign sdo_o = 1'b0;

endmodule

// file: src/amc_pkg.sv
// constants shared by the converter mode-control register bank
package amc_pkg;

  // ==========================================================
  // register map
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [6:0] ADDR_FMT_PWR = 7'h01;
  localparam logic [6:0] ADDR_OUT_MODE = 7'h02;
  localparam logic [6:0] ADDR_PAT_HI = 7'h03;
  localparam logic [6:0] ADDR_PAT_LO = 7'h04;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;

  // ==========================================================
  // field positions
  localparam int SRST_BIT = 7;
  localparam int SLEEP_BIT = 4;
  localparam int NAP_MSB = 3;
  localparam int CUR_MSB = 7;
  localparam int CUR_LSB = 5;
  localparam int TERM_BIT = 4;
  localparam int OFF_BIT = 3;
  localparam int MODE_MSB = 2;
  localparam int TEST_EN_BIT = 7;
  localparam int PHI_MSB = 5;
  localparam int NUM_CHAN = 4;

  // ==========================================================
  // serial word framing
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] HDR_BITS = 5'h08;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int SRST_TIME_NS = 100;
  localparam logic [3:0] SRST_CYCLES =
    4'((SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================
  // driver current codes and currents in microamps
  typedef enum logic [2:0] {
    CUR_3P5 = 3'b000,
    CUR_4P0 = 3'b001,
    CUR_4P5 = 3'b010,
    CUR_NONE = 3'b011,
    CUR_3P0 = 3'b100,
    CUR_2P5 = 3'b101,
    CUR_2P1 = 3'b110,
    CUR_1P75 = 3'b111
  } amc_cur_t;
  localparam logic [13:0] UA_3P5 = 14'h0dac;
  localparam logic [13:0] UA_4P0 = 14'h0fa0;
  localparam logic [13:0] UA_4P5 = 14'h1194;
  localparam logic [13:0] UA_3P0 = 14'h0bb8;
  localparam logic [13:0] UA_2P5 = 14'h09c4;
  localparam logic [13:0] UA_2P1 = 14'h0834;
  localparam logic [13:0] UA_1P75 = 14'h06d6;

  // ==========================================================
  // lane and framing modes
  typedef enum logic [2:0] {
    LM_2L16 = 3'b000,
    LM_2L14 = 3'b001,
    LM_2L12 = 3'b010,
    LM_NU3 = 3'b011,
    LM_NU4 = 3'b100,
    LM_1L14 = 3'b101,
    LM_1L16A = 3'b110,
    LM_1L16B = 3'b111
  } amc_lane_t;

endpackage

// file: src/amc_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module amc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // pins in, synchronised levels out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule

// file: src/amc_spi_port.sv
// serial configuration word engine: shift in, write strobe, readback
`timescale 1ns/1ps
module amc_spi_port
  import amc_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // synchronised pins
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  // register side
  input wire logic [7:0] rdata_i,
  output logic [6:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  // open-drain data out enable
  output logic sdo_oe_o
);
  logic sck_d_reg;
  logic [4:0] cnt_reg;
  logic [15:0] sh_reg;
  logic load_reg;
  logic rd_mode_reg;
  logic [7:0] rd_reg;
  logic wr_reg;
  logic oe_reg;

  wire rise = sck_i & ~sck_d_reg;
  wire fall = ~sck_i & sck_d_reg;
  wire take = rise & (cnt_reg < WORD_BITS);
  wire last = rise & (cnt_reg == WORD_BITS - 5'h01);
  wire hdr_end = rise & (cnt_reg == HDR_BITS - 5'h01);
  wire drive = fall & rd_mode_reg & (cnt_reg >= HDR_BITS)
    & (cnt_reg < WORD_BITS);

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sck_d_reg <= 1'b0;
      cnt_reg <= 5'h00;
      sh_reg <= 16'h0000;
      load_reg <= 1'b0;
      rd_mode_reg <= 1'b0;
      rd_reg <= 8'h00;
      wr_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      sck_d_reg <= sck_i;
      wr_reg <= ~cs_n_i & last & ~sh_reg[14];
      load_reg <= ~cs_n_i & hdr_end & sh_reg[6];
      if (cs_n_i) begin
        cnt_reg <= 5'h00;
        rd_mode_reg <= 1'b0;
        oe_reg <= 1'b0;
      end else begin
        // edges beyond the sixteenth are ignored
        if (take) begin
          sh_reg <= {sh_reg[14:0], sdi_i};
          cnt_reg <= cnt_reg + 5'h01;
        end
        if (hdr_end) begin
          rd_mode_reg <= sh_reg[6];
        end
        if (load_reg) begin
          rd_reg <= rdata_i;
        end else if (drive) begin
          oe_reg <= ~rd_reg[7];
          rd_reg <= {rd_reg[6:0], 1'b0};
        end
      end
    end
  end

  assign addr_o = (cnt_reg == WORD_BITS) ? sh_reg[14:8] : sh_reg[6:0];
  assign wdata_o = sh_reg[7:0];
  assign wr_o = wr_reg;
  assign sdo_oe_o = oe_reg;
endmodule

// file: sim/amc_regs_assertions.sv
// port checker for the mode-control register bank
`timescale 1ns/1ps
module amc_regs_assertions
  import amc_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // watched ports
  input wire logic sdo_o,
  input wire logic [13:0] conv_data_i,
  input wire logic [13:0] out_data_o,
  input wire logic out_drive_en_o,
  input wire logic sleep_o,
  input wire logic [3:0] chan_nap_o,
  input wire logic [3:0] chan_run_o,
  input wire logic [2:0] driver_current_code_o,
  input wire logic internal_termination_enable_o,
  input wire logic [13:0] drive_current_ua_o,
  input wire logic output_disable_o,
  input wire logic [2:0] lane_serialization_mode_o,
  input wire logic two_lane_o,
  input wire logic [4:0] frame_bits_o,
  input wire logic lane_mode_valid_o,
  input wire logic test_pattern_enable_o
);
  // ==========================================================
  // assertions
  // registered outputs lag reset release by one edge, hence $past(nrst_i)
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sleep_all_off_a: assert property (
    sleep_o |-> chan_run_o == 4'h0 && chan_nap_o == 4'h0)
    else $error("channels active while asleep");
  nap_run_split_a: assert property (
    $past(nrst_i) && !sleep_o |-> chan_run_o == ~chan_nap_o)
    else $error("nap and run disagree");
  drive_enable_a: assert property (
    $past(nrst_i) |-> out_drive_en_o == !$past(output_disable_o))
    else $error("driver enable wrong");
  normal_data_a: assert property (
    $past(nrst_i) && !$past(test_pattern_enable_o)
    |-> out_data_o == $past(conv_data_i))
    else $error("conversion data not passed");
  lane_count_a: assert property (
    $past(nrst_i)
    |-> two_lane_o == ($past(lane_serialization_mode_o) < 3'h5))
    else $error("lane count wrong");
  lane_valid_a: assert property (
    $past(nrst_i) |-> lane_mode_valid_o !=
    ($past(lane_serialization_mode_o) inside {3'h3, 3'h4}))
    else $error("lane validity wrong");
  frame_twelve_a: assert property (
    $past(nrst_i) && $past(lane_serialization_mode_o) == 3'h2
    |-> frame_bits_o == 5'h0c)
    else $error("frame length wrong");
  term_double_a: assert property (
    $past(nrst_i) && $past(internal_termination_enable_o)
    && $past(driver_current_code_o) == 3'h5
    |-> drive_current_ua_o == 14'h1388)
    else $error("terminated current not doubled");
  unused_current_a: assert property (
    $past(nrst_i) && $past(driver_current_code_o) == 3'h3
    |-> drive_current_ua_o == 14'h0000)
    else $error("unused current code drives");
  sdo_low_only_a: assert property (
    sdo_o == 1'b0)
    else $error("data out pin driven high");
  cover property (sleep_o);
  cover property (test_pattern_enable_o);
  cover property (internal_termination_enable_o && !two_lane_o);
endmodule

bind amc_regs amc_regs_assertions u_chk (.*);

// file: sim/amc_host.sv
// serial configuration host model
`timescale 1ns/1ps
module amc_host (
  // clock
  input wire logic clock_i,
  // serial pins
  output logic cs_n_o,
  output logic sck_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  // clock cycles per serial clock phase; raise it for a slow host
  int half = 6;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  // flag, address, data, msb first, framed by chip select
  task automatic xfer(input logic rw, input logic [6:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    logic [15:0] w;
    w = {rw, a, d};
    q = 8'h00;
    @(negedge clock_i);
    cs_n_o = 1'b0;
    repeat (4) @(negedge clock_i);
    for (int i = 15; i >= 0; i--) begin
      sdi_o = w[i];
      repeat (half) @(negedge clock_i);
      sck_o = 1'b1;
      if (i < 8) q[i] = sdo_i;
      repeat (half) @(negedge clock_i);
      sck_o = 1'b0;
    end
    repeat (4) @(negedge clock_i);
    cs_n_o = 1'b1;
    // released data line must not keep its last level
    sdi_o = ~sdi_o;
    repeat (8) @(negedge clock_i);
  endtask
endmodule

// file: sim/adc_mode_control_registers_bench.sv
// self-checking bench for the mode-control register bank
`timescale 1ns/1ps
module adc_mode_control_registers_bench;
  import amc_pkg::*;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic programming_mode_select_i = 1'b0;
  logic cs_n, sck, sdi, sdo_o, sdo_oe_o, sdo_w;
  logic [13:0] conv_data_i = 14'h0000;
  logic [13:0] out_data_o, drive_current_ua_o;
  logic out_drive_en_o, sleep_o, output_disable_o, two_lane_o;
  logic [3:0] chan_nap_o, chan_run_o;
  logic [2:0] driver_current_code_o, lane_serialization_mode_o;
  logic internal_termination_enable_o, lane_mode_valid_o;
  logic test_pattern_enable_o;
  logic [4:0] frame_bits_o;
  logic [7:0] q, v;
  logic [28:0] r;
  int num_errors = 0, compares = 0, cycles = 0, slp = 0;
  // every current code and lane mode, then termination at low currents, then output off
  // written value, then current, lane count, frame bits, validity
  logic [28:0] rows [11] = '{
    {8'h00, 14'h0dac, 1'b1, 5'h10, 1'b1}, {8'h21, 14'h0fa0, 1'b1, 5'h0e, 1'b1},
    {8'h42, 14'h1194, 1'b1, 5'h0c, 1'b1}, {8'h63, 14'h0000, 1'b1, 5'h10, 1'b0},
    {8'h84, 14'h0bb8, 1'b1, 5'h10, 1'b0}, {8'ha5, 14'h09c4, 1'b0, 5'h0e, 1'b1},
    {8'hc6, 14'h0834, 1'b0, 5'h10, 1'b1}, {8'hb5, 14'h1388, 1'b0, 5'h0e, 1'b1},
    {8'hd7, 14'h1068, 1'b0, 5'h10, 1'b1}, {8'hf0, 14'h0dac, 1'b1, 5'h10, 1'b1},
    {8'h08, 14'h0dac, 1'b1, 5'h10, 1'b1}};
  logic [7:0] pw [4] = '{8'h05, 8'h1a, 8'h0a, 8'h00};
  // open-drain data out with pull-up
  assign sdo_w = sdo_oe_o ? sdo_o : 1'b1;
  always #12.5 clock_i = ~clock_i;
  always @(negedge clock_i) conv_data_i <= conv_data_i + 14'h0001;
  always @(posedge clock_i) if (sleep_o === 1'b1) slp <= slp + 1;
  amc_host u_host (.clock_i(clock_i), .cs_n_o(cs_n), .sck_o(sck),
    .sdi_o(sdi), .sdo_i(sdo_w));
  amc_regs u_dut (.clock_i(clock_i), .nrst_i(nrst_i),
    .programming_mode_select_i(programming_mode_select_i),
    .cs_n_i(cs_n), .sck_i(sck), .sdi_i(sdi), .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o), .conv_data_i(conv_data_i),
    .out_data_o(out_data_o), .out_drive_en_o(out_drive_en_o),
    .sleep_o(sleep_o), .chan_nap_o(chan_nap_o), .chan_run_o(chan_run_o),
    .driver_current_code_o(driver_current_code_o),
    .internal_termination_enable_o(internal_termination_enable_o),
    .drive_current_ua_o(drive_current_ua_o),
    .output_disable_o(output_disable_o),
    .lane_serialization_mode_o(lane_serialization_mode_o),
    .two_lane_o(two_lane_o), .frame_bits_o(frame_bits_o),
    .lane_mode_valid_o(lane_mode_valid_o),
    .test_pattern_enable_o(test_pattern_enable_o));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    u_host.xfer(1'b0, a, d, x);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    u_host.xfer(1'b1, a, 8'h00, d);
  endtask
  task automatic end_sim;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // a full run needs about 7500 cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim;
    end
  end
  // ==========================================================
  // sequence
  initial begin
    repeat (6) @(negedge clock_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge clock_i);
    chk({sleep_o, chan_run_o, out_drive_en_o}, 6'h1f);
    foreach (rows[i]) begin
      r = rows[i];
      wr(ADDR_OUT_MODE, r[28:21]);
      chk({driver_current_code_o, internal_termination_enable_o,
        output_disable_o, lane_serialization_mode_o}, r[28:21]);
      chk({drive_current_ua_o, two_lane_o, frame_bits_o,
        lane_mode_valid_o}, r[20:0]);
      chk(out_drive_en_o, {~r[24]});
      rd(ADDR_OUT_MODE, q);
      chk(q, r[28:21]);
    end
    foreach (pw[i]) begin
      v = pw[i];
      wr(ADDR_FMT_PWR, v);
      chk({sleep_o, chan_nap_o, chan_run_o},
        v[4] ? 9'h100 : {1'b0, v[3:0], ~v[3:0]});
    end
    wr(ADDR_PAT_LO, 8'hb6);
    wr(ADDR_PAT_HI, 8'hc5);
    chk(test_pattern_enable_o, 1'b1);
    chk(out_data_o, {6'h05, 8'hb6});
    wr(ADDR_PAT_HI, 8'h85);
    chk(out_data_o, {6'h05, 8'hb6});
    // pin programming mode leaves the serial port deaf
    programming_mode_select_i = 1'b1;
    wr(ADDR_PAT_LO, 8'h00);
    programming_mode_select_i = 1'b0;
    chk(out_data_o, {6'h05, 8'hb6});
    u_host.half = 10;
    rd(ADDR_PAT_LO, q);
    u_host.half = 6;
    chk(q, 8'hb6);
    rd(7'h10, q);
    chk(q, 8'h00);
    slp = 0;
    wr(ADDR_RESET, 8'h80);
    chk(slp, 4);
    rd(ADDR_RESET, q);
    chk(q, 8'h00);
    chk({test_pattern_enable_o, out_drive_en_o, chan_run_o}, 6'h1f);
    // hardware reset in mid-run clears a written output mode
    wr(ADDR_OUT_MODE, 8'h08);
    chk(output_disable_o, 1'b1);
    nrst_i = 1'b0;
    repeat (2) @(negedge clock_i);
    chk({out_drive_en_o, output_disable_o, chan_run_o}, 6'h00);
    nrst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    chk({out_drive_en_o, output_disable_o, chan_run_o}, 6'h2f);
    end_sim;
  end
endmodule
